// >>> design/freq_ref_pkg.sv
package freq_ref_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0]  ADR_SRC_CFG     = 8'h00;
    localparam logic [7:0]  ADR_FULL_SCALE  = 8'h04;
    localparam logic [7:0]  ADR_ANALOG_CFG  = 8'h08;
    localparam logic [7:0]  ADR_PANEL_REF   = 8'h0C;
    localparam logic [7:0]  ADR_FREQ_REF    = 8'h10;
    localparam logic [7:0]  ADR_PULSE_HZ    = 8'h14;
    localparam logic [7:0]  ADR_PULSE_PCT   = 8'h18;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int          SRC_LSB         = 0;
    localparam int          PF_LSB          = 4;
    localparam int          IN2_LEVEL_LSB   = 0;
    localparam int          IN2_FUNC_LSB    = 8;
    localparam int          IN3_FUNC_LSB    = 16;
    localparam int          DI_FUNC_LSB     = 24;

    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [2:0]  SRC_RST         = 3'h1;
    localparam logic [1:0]  PF_RST          = 2'h0;
    localparam logic [15:0] FS_RST          = 16'h05A0;
    localparam logic [15:0] FS_MIN          = 16'h03E8;
    localparam logic [15:0] FS_MAX          = 16'h7D00;
    localparam logic [1:0]  IN2_LEVEL_RST   = 2'h0;
    localparam logic [4:0]  IN2_FUNC_RST    = 5'h00;
    localparam logic [4:0]  IN3_FUNC_RST    = 5'h1F;
    localparam logic [4:0]  DI_FUNC_RST     = 5'h03;
    localparam logic [15:0] PANEL_RST       = 16'h0000;

    localparam logic [2:0]  SRC_PANEL       = 3'h0;
    localparam logic [2:0]  SRC_ANALOG      = 3'h1;
    localparam logic [2:0]  SRC_SERIAL      = 3'h2;
    localparam logic [2:0]  SRC_OPTION      = 3'h3;
    localparam logic [2:0]  SRC_PULSE       = 3'h4;
    localparam logic [1:0]  PF_FREQ         = 2'h0;
    localparam logic [1:0]  PF_PID_FB       = 2'h1;
    localparam logic [1:0]  PF_PID_TGT      = 2'h2;
    localparam logic [1:0]  IN2_LEVEL_CUR   = 2'h2;
    localparam logic [4:0]  IN2_FUNC_ADD    = 5'h00;
    localparam logic [4:0]  IN3_FUNC_AUX    = 5'h02;
    localparam logic [4:0]  DI_FUNC_STEP1   = 5'h03;

    // 100.00 % in units of 0.01 %
    localparam logic [15:0] PCT_FULL        = 16'h2710;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int          CLK_HZ          = 20000000;
    localparam int          GATE_MS         = 100;
    localparam int          GATE_CYCLES     = CLK_HZ / 1000 * GATE_MS;
    localparam logic [3:0]  HZ_PER_COUNT    = 4'(1000 / GATE_MS);
    localparam logic [4:0]  DIV_STEPS       = 5'h1D;

endpackage

// >>> design/freq_ref_select.sv
// How it works
// - Source code 0..4 picks panel, analog, serial, option or pulse; resets to 1.
// - Source 0 uses the operator panel reference value.
// - Source 1 uses the first analog input, or first plus second.
// - Second input added to first when its function is 0 (current mode included).
// - Step-1 input off selects master analog, on selects third analog input.
// - Third analog input is auxiliary only when its function equals 2.
// - Source 4 uses the pulse-train percentage as the reference.
// - Pulse function 0 reference, 1 PID feedback, 2 PID target.
// - Pulse frequency equal to full scale (1000..32000, reset 1440) gives 100 %.
// - Digital input function 3 makes it step-1 and master/auxiliary switch.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module freq_ref_select
    import freq_ref_pkg::*;
#(
    parameter int GATE_CYC = GATE_CYCLES
)(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] analog_in_first_i,
    input  wire logic [15:0] analog_in_second_i,
    input  wire logic [15:0] analog_in_third_i,
    input  wire logic [15:0] serial_ref_i,
    input  wire logic [15:0] option_ref_i,
    input  wire logic        pulse_train_pin_i,
    input  wire logic        step1_pin_i,
    output logic      [15:0] freq_ref_o,
    output logic      [15:0] pid_feedback_o,
    output logic      [15:0] pid_target_o,
    output logic             aux_selected_o
);

    logic [2:0]  reference_source_select, next_src;
    logic [1:0]  pulse_input_function, next_pf;
    logic [15:0] pulse_input_full_scale, next_fs;
    logic [1:0]  analog_in2_level_type, next_in2_level;
    logic [4:0]  analog_in2_function, next_in2_func;
    logic [4:0]  analog_in3_function, next_in3_func;
    logic [4:0]  digital_input_function, next_di_func;
    logic [15:0] panel_ref, next_panel;
    logic [31:0] next_dat;
    logic        next_ack;
    logic [15:0] next_freq, next_pid_fb, next_pid_tgt;
    logic        next_aux;
    logic        step1_meta, step1_sync;
    logic [31:0] wmask, rd_word, merged;
    logic        bus_req, bus_wr;
    logic [16:0] sum_first_second;
    logic [15:0] master_ref;
    logic        step1_active, aux_active;
    logic [15:0] pulse_hz, pulse_pct;
    logic        pct_done;

    pulse_meter #(
        .GATE_CYC     (GATE_CYC)
    ) u_meter (
        .mclk_i       (mclk_i),
        .srst_i       (srst_i),
        .pulse_i      (pulse_train_pin_i),
        .full_scale_i (pulse_input_full_scale),
        .freq_hz_o    (pulse_hz),
        .percent_o    (pulse_pct),
        .done_o       (pct_done)
    );

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    genvar g;
    for (g = 0; g < 4; g++) begin : g_lane
        assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
    end

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;
    assign merged  = (rd_word & ~wmask) | (wb_dat_i & wmask);

    always_comb begin
        rd_word = 32'h0;
        case (wb_adr_i)
            ADR_SRC_CFG: begin
                rd_word[SRC_LSB +: 3] = reference_source_select;
                rd_word[PF_LSB +: 2]  = pulse_input_function;
            end
            ADR_FULL_SCALE: rd_word[15:0] = pulse_input_full_scale;
            ADR_ANALOG_CFG: begin
                rd_word[IN2_LEVEL_LSB +: 2] = analog_in2_level_type;
                rd_word[IN2_FUNC_LSB +: 5]  = analog_in2_function;
                rd_word[IN3_FUNC_LSB +: 5]  = analog_in3_function;
                rd_word[DI_FUNC_LSB +: 5]   = digital_input_function;
            end
            ADR_PANEL_REF: rd_word[15:0] = panel_ref;
            ADR_FREQ_REF:  rd_word[15:0] = freq_ref_o;
            ADR_PULSE_HZ:  rd_word[15:0] = pulse_hz;
            ADR_PULSE_PCT: rd_word[15:0] = pulse_pct;
            default:       rd_word = 32'h0;
        endcase
    end

    // Out-of-range settings are dropped so the selector never sees an undefined code
    always_comb begin
        next_ack      = bus_req;
        next_dat      = bus_req ? rd_word : 32'h0;
        next_src      = reference_source_select;
        next_pf       = pulse_input_function;
        next_fs       = pulse_input_full_scale;
        next_in2_level = analog_in2_level_type;
        next_in2_func  = analog_in2_function;
        next_in3_func  = analog_in3_function;
        next_di_func  = digital_input_function;
        next_panel    = panel_ref;
        if (bus_wr) begin
            case (wb_adr_i)
                ADR_SRC_CFG: begin
                    if (merged[SRC_LSB +: 3] <= SRC_PULSE) begin
                        next_src = merged[SRC_LSB +: 3];
                    end
                    if (merged[PF_LSB +: 2] <= PF_PID_TGT) begin
                        next_pf = merged[PF_LSB +: 2];
                    end
                end
                ADR_FULL_SCALE: begin
                    if (merged[15:0] >= FS_MIN && merged[15:0] <= FS_MAX) begin
                        next_fs = merged[15:0];
                    end
                end
                ADR_ANALOG_CFG: begin
                    next_in2_level = merged[IN2_LEVEL_LSB +: 2];
                    next_in2_func  = merged[IN2_FUNC_LSB +: 5];
                    next_in3_func  = merged[IN3_FUNC_LSB +: 5];
                    next_di_func  = merged[DI_FUNC_LSB +: 5];
                end
                ADR_PANEL_REF: next_panel = merged[15:0];
                default: next_ack = bus_req;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wb_ack_o                <= 1'b0;
            wb_dat_o                <= 32'h0;
            reference_source_select <= SRC_RST;
            pulse_input_function    <= PF_RST;
            pulse_input_full_scale  <= FS_RST;
            analog_in2_level_type   <= IN2_LEVEL_RST;
            analog_in2_function     <= IN2_FUNC_RST;
            analog_in3_function     <= IN3_FUNC_RST;
            digital_input_function  <= DI_FUNC_RST;
            panel_ref               <= PANEL_RST;
        end else begin
            wb_ack_o                <= next_ack;
            wb_dat_o                <= next_dat;
            reference_source_select <= next_src;
            pulse_input_function    <= next_pf;
            pulse_input_full_scale  <= next_fs;
            analog_in2_level_type   <= next_in2_level;
            analog_in2_function     <= next_in2_func;
            analog_in3_function     <= next_in3_func;
            digital_input_function  <= next_di_func;
            panel_ref               <= next_panel;
        end
    end

    // ----------------------------------------
    // Reference selection
    // ----------------------------------------
    assign step1_active = step1_sync && (digital_input_function == DI_FUNC_STEP1);
    assign aux_active   = step1_active && (analog_in3_function == IN3_FUNC_AUX);
    assign sum_first_second = {1'b0, analog_in_first_i} + {1'b0, analog_in_second_i};

    always_comb begin
        // Sum saturates rather than wrapping to a low speed
        if (analog_in2_function == IN2_FUNC_ADD) begin
            master_ref = sum_first_second[16] ? 16'hFFFF : sum_first_second[15:0];
        end else begin
            master_ref = analog_in_first_i;
        end
        next_aux = aux_active;
        case (reference_source_select)
            SRC_PANEL:  next_freq = panel_ref;
            SRC_ANALOG: next_freq = aux_active ? analog_in_third_i : master_ref;
            SRC_SERIAL: next_freq = serial_ref_i;
            SRC_OPTION: next_freq = option_ref_i;
            SRC_PULSE:  next_freq = (pulse_input_function == PF_FREQ) ? pulse_pct : 16'h0;
            default:    next_freq = 16'h0;
        endcase
        next_pid_fb  = pid_feedback_o;
        next_pid_tgt = pid_target_o;
        if (pct_done && pulse_input_function == PF_PID_FB) begin
            next_pid_fb = pulse_pct;
        end
        if (pct_done && pulse_input_function == PF_PID_TGT) begin
            next_pid_tgt = pulse_pct;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            step1_meta     <= 1'b0;
            step1_sync     <= 1'b0;
            freq_ref_o     <= 16'h0;
            pid_feedback_o <= 16'h0;
            pid_target_o   <= 16'h0;
            aux_selected_o <= 1'b0;
        end else begin
            step1_meta     <= step1_pin_i;
            step1_sync     <= step1_meta;
            freq_ref_o     <= next_freq;
            pid_feedback_o <= next_pid_fb;
            pid_target_o   <= next_pid_tgt;
            aux_selected_o <= next_aux;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_src_reset;
        @(posedge mclk_i) $fell(srst_i) |-> (reference_source_select == SRC_RST);
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source not 1 after reset");

    property p_src_ext;
        @(posedge mclk_i) disable iff (srst_i)
        (reference_source_select == SRC_SERIAL) ##1 (reference_source_select == SRC_OPTION)
            |=> (freq_ref_o == $past(option_ref_i));
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("option reference not used");

    property p_panel;
        @(posedge mclk_i) disable iff (srst_i)
        (reference_source_select == SRC_PANEL) |=> (freq_ref_o == $past(panel_ref));
    endproperty
    a_panel: assert property (p_panel) else $error("panel reference not used");

    property p_first_only;
        @(posedge mclk_i) disable iff (srst_i)
        (reference_source_select == SRC_ANALOG && !aux_active
            && analog_in2_function != IN2_FUNC_ADD)
            |=> (freq_ref_o == $past(analog_in_first_i));
    endproperty
    a_first_only: assert property (p_first_only) else $error("first analog not used");

    property p_add_second;
        @(posedge mclk_i) disable iff (srst_i)
        (reference_source_select == SRC_ANALOG && !aux_active
            && analog_in2_level_type == IN2_LEVEL_CUR && analog_in2_function == IN2_FUNC_ADD)
            |=> (freq_ref_o == ($past(sum_first_second[16]) ? 16'hFFFF
                : $past(sum_first_second[15:0])));
    endproperty
    a_add_second: assert property (p_add_second) else $error("second input not added");

    property p_aux_switch;
        @(posedge mclk_i) disable iff (srst_i)
        (reference_source_select == SRC_ANALOG && aux_active)
            |=> (freq_ref_o == $past(analog_in_third_i)) && aux_selected_o;
    endproperty
    a_aux_switch: assert property (p_aux_switch) else $error("third analog not used");

    property p_aux_func;
        @(posedge mclk_i) disable iff (srst_i)
        (analog_in3_function != IN3_FUNC_AUX) |=> !aux_selected_o;
    endproperty
    a_aux_func: assert property (p_aux_func) else $error("aux without function 2");

    property p_pulse_ref;
        @(posedge mclk_i) disable iff (srst_i)
        (reference_source_select == SRC_PULSE && pulse_input_function == PF_FREQ)
            |=> (freq_ref_o == $past(pulse_pct));
    endproperty
    a_pulse_ref: assert property (p_pulse_ref) else $error("pulse reference not used");

    property p_pid_route;
        @(posedge mclk_i) disable iff (srst_i)
        (pct_done && pulse_input_function == PF_PID_FB)
            |=> (pid_feedback_o == $past(pulse_pct)) && $stable(pid_target_o);
    endproperty
    a_pid_route: assert property (p_pid_route) else $error("PID feedback not routed");

    property p_step1_func;
        @(posedge mclk_i) disable iff (srst_i)
        (digital_input_function != DI_FUNC_STEP1) |=> !aux_selected_o;
    endproperty
    a_step1_func: assert property (p_step1_func) else $error("aux without step-1 input");

endmodule

`default_nettype wire

// >>> design/pulse_meter.sv
`timescale 1ns/1ps
`default_nettype none

module pulse_meter
    import freq_ref_pkg::*;
#(
    parameter int GATE_CYC = GATE_CYCLES
)(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        pulse_i,
    input  wire logic [15:0] full_scale_i,
    output logic      [15:0] freq_hz_o,
    output logic      [15:0] percent_o,
    output logic             done_o
);

    typedef enum logic {IDLE, DIVIDE} div_state_type;

    logic          sync1, sync2, sync3;
    logic [31:0]   gate_cnt, next_gate_cnt;
    logic [15:0]   edge_cnt, next_edge_cnt;
    logic [15:0]   next_freq, next_percent;
    logic          next_done;
    div_state_type state, next_state;
    logic [28:0]   acc, next_acc;
    logic [16:0]   rem, next_rem;
    logic [4:0]    step, next_step;
    logic          gate_end;
    logic          rise;
    logic [19:0]   freq_prod;
    logic [15:0]   freq_calc;
    logic [29:0]   dividend;
    logic [16:0]   trial;

    assign gate_end  = (gate_cnt == 32'(GATE_CYC - 1));
    assign rise      = sync2 & ~sync3;
    assign freq_prod = 20'(edge_cnt) * 20'(HZ_PER_COUNT);
    assign freq_calc = (freq_prod > 20'h0FFFF) ? 16'hFFFF : freq_prod[15:0];
    assign dividend  = 30'(freq_calc) * 30'(PCT_FULL);
    assign trial     = {rem[15:0], acc[28]};

    // ----------------------------------------
    // Gate counter and proportional divider
    // ----------------------------------------
    always_comb begin
        next_gate_cnt = gate_end ? 32'h0 : gate_cnt + 32'h1;
        next_edge_cnt = edge_cnt;
        if (gate_end) begin
            next_edge_cnt = {15'h0, rise};
        end else if (rise && edge_cnt != 16'hFFFF) begin
            next_edge_cnt = edge_cnt + 16'h1;
        end
        next_freq    = freq_hz_o;
        next_percent = percent_o;
        next_done    = 1'b0;
        next_state   = state;
        next_acc     = acc;
        next_rem     = rem;
        next_step    = step;
        case (state)
            IDLE: begin
                if (gate_end) begin
                    next_freq = freq_calc;
                    if (freq_calc >= full_scale_i) begin
                        // Above full scale the reference saturates at 100 %
                        next_percent = PCT_FULL;
                        next_done    = 1'b1;
                    end else begin
                        next_acc   = dividend[28:0];
                        next_rem   = 17'h0;
                        next_step  = 5'h0;
                        next_state = DIVIDE;
                    end
                end
            end
            DIVIDE: begin
                if (trial >= {1'b0, full_scale_i}) begin
                    next_rem = trial - {1'b0, full_scale_i};
                    next_acc = {acc[27:0], 1'b1};
                end else begin
                    next_rem = trial;
                    next_acc = {acc[27:0], 1'b0};
                end
                next_step = step + 5'h1;
                if (step == DIV_STEPS - 5'h1) begin
                    next_percent = next_acc[15:0];
                    next_done    = 1'b1;
                    next_state   = IDLE;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            sync3     <= 1'b0;
            gate_cnt  <= 32'h0;
            edge_cnt  <= 16'h0;
            freq_hz_o <= 16'h0;
            percent_o <= 16'h0;
            done_o    <= 1'b0;
            state     <= IDLE;
            acc       <= 29'h0;
            rem       <= 17'h0;
            step      <= 5'h0;
        end else begin
            sync1     <= pulse_i;
            sync2     <= sync1;
            sync3     <= sync2;
            gate_cnt  <= next_gate_cnt;
            edge_cnt  <= next_edge_cnt;
            freq_hz_o <= next_freq;
            percent_o <= next_percent;
            done_o    <= next_done;
            state     <= next_state;
            acc       <= next_acc;
            rem       <= next_rem;
            step      <= next_step;
        end
    end

    property p_pct_cap;
        @(posedge mclk_i) disable iff (srst_i)
        done_o |-> (percent_o <= PCT_FULL);
    endproperty
    a_pct_cap: assert property (p_pct_cap) else $error("percent above full scale");

    property p_sat_full;
        @(posedge mclk_i) disable iff (srst_i)
        (gate_end && state == IDLE && freq_calc >= full_scale_i)
            |=> (done_o && percent_o == PCT_FULL);
    endproperty
    a_sat_full: assert property (p_sat_full) else $error("full scale not 100 percent");

    property p_gate_len;
        @(posedge mclk_i) disable iff (srst_i)
        gate_end |=> (gate_cnt == 32'h0) ##1 (gate_cnt == 32'h1);
    endproperty
    a_gate_len: assert property (p_gate_len) else $error("gate counter did not restart");

endmodule

`default_nettype wire

// >>> testbench/ref_source_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Pulse generator on the far side
// ----------------------------------------
// A period of 0 keeps the pin low, so no stray edges appear between tests
module ref_source_model (
    input  wire logic       mclk_i,
    input  wire logic [7:0] period_i,
    output logic            pulse_o
);
    logic [7:0] phase = 8'h00;
    always_ff @(posedge mclk_i) begin
        phase <= (phase + 8'h01 >= period_i) ? 8'h00 : phase + 8'h01;
    end
    assign pulse_o = (period_i != 8'h00) && (phase < (period_i >> 1));
endmodule

`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import freq_ref_pkg::*;
    localparam int GATE = 2000;
    logic        mclk_i, srst_i, cyc, stb, we, step1, ack, pulse;
    logic [7:0]  adr, period;
    logic [31:0] wdat, rdat, got;
    logic [15:0] in1, in2, in3, ser, opt, fref, pfb, ptg;
    logic        aux;
    int          num_errors, samples_checked;

    freq_ref_select #(.GATE_CYC(GATE)) u_dut (.mclk_i(mclk_i), .srst_i(srst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .analog_in_first_i(in1),
        .analog_in_second_i(in2), .analog_in_third_i(in3), .serial_ref_i(ser),
        .option_ref_i(opt), .pulse_train_pin_i(pulse), .step1_pin_i(step1),
        .freq_ref_o(fref), .pid_feedback_o(pfb), .pid_target_o(ptg), .aux_selected_o(aux));
    ref_source_model u_src (.mclk_i(mclk_i), .period_i(period), .pulse_o(pulse));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // The request stands until the rising edge that samples ack high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            $display("Error wb_ack expected 1 seen %b", ack);
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk("reg", exp, got);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    initial begin
        logic [15:0] exp_src [4];
        {srst_i, cyc, stb, we, step1, adr, wdat, period} = {1'b1, 4'h0, 8'h00, 32'h0, 8'h00};
        {in1, in2, in3, ser, opt} = {16'h0100, 16'h0020, 16'h0777, 16'h2222, 16'h3333};
        num_errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd(ADR_SRC_CFG, 32'h0000_0001);
        rd(ADR_FULL_SCALE, 32'h0000_05A0);
        rd(ADR_ANALOG_CFG, 32'h031F_0000);
        rd(8'h40, 32'h0000_0000);
        wb(1'b1, ADR_PANEL_REF, 32'h0000_1234);
        exp_src = '{16'h1234, 16'h0120, 16'h2222, 16'h3333};
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, ADR_SRC_CFG, 32'(s));
            settle(4);
            chk("freq_ref", 32'(exp_src[s]), 32'(fref));
        end
        wb(1'b1, ADR_SRC_CFG, 32'h0000_0005);
        rd(ADR_SRC_CFG, 32'h0000_0003);
        // Current level type with add function still sums the two inputs
        wb(1'b1, ADR_SRC_CFG, 32'h0000_0001);
        wb(1'b1, ADR_ANALOG_CFG, 32'h0302_0002);
        settle(4);
        chk("master", 32'h0120, 32'(fref));
        @(posedge mclk_i) step1 <= 1'b1;
        settle(4);
        chk("aux", 32'h0001_0777, {15'h0, aux, fref});
        wb(1'b1, ADR_ANALOG_CFG, 32'h031F_0002);
        settle(4);
        chk("a3_unused", 32'h0000_0120, {15'h0, aux, fref});
        wb(1'b1, ADR_ANALOG_CFG, 32'h0402_0002);
        settle(4);
        chk("di_other", 32'h0000_0120, {15'h0, aux, fref});
        @(posedge mclk_i) step1 <= 1'b0;
        // Second input not used: first input alone is the master reference
        wb(1'b1, ADR_ANALOG_CFG, 32'h0302_1F02);
        settle(4);
        chk("first_only", 32'h0000_0100, {15'h0, aux, fref});
        // 40-cycle period gives exactly 50 edges per gate, 500 Hz
        wb(1'b1, ADR_FULL_SCALE, 32'h0000_03E8);
        wb(1'b1, ADR_FULL_SCALE, 32'h0000_03E7);
        rd(ADR_FULL_SCALE, 32'h0000_03E8);
        wb(1'b1, ADR_SRC_CFG, 32'h0000_0004);
        period <= 8'd40;
        settle(2 * GATE + 100);
        rd(ADR_PULSE_HZ, 32'h0000_01F4);
        chk("pulse_ref", 32'h1388, 32'(fref));
        wb(1'b1, ADR_SRC_CFG, 32'h0000_0014);
        settle(GATE + 100);
        chk("pid_fb", 32'h1388_0000, {pfb, fref});
        wb(1'b1, ADR_SRC_CFG, 32'h0000_0024);
        settle(GATE + 100);
        chk("pid_tgt", 32'h1388, 32'(ptg));
        wb(1'b1, ADR_SRC_CFG, 32'h0000_0004);
        period <= 8'd10;
        settle(2 * GATE + 100);
        chk("saturate", 32'(PCT_FULL), 32'(fref));
        print_verdict();
    end
endmodule

`default_nettype wire
